// ==== pkg/ufc_params.svh ====
// offsets, field positions, reset values and counts for the serial frame/irq control
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH

`define UFC_ADDR_W          16
`define UFC_OFS_LINE_CTRL   16'hf300
`define UFC_OFS_DMA_IRQ     16'hf304
`define UFC_OFS_IRQ_STATUS  16'hf308
`define UFC_OFS_SC_STATUS   16'hf30c
`define UFC_OFS_IRQ_ENABLE  16'hf340
`define UFC_OFS_IRQ_CLEAR   16'hf344

`define UFC_LC_RX_WAKE      15
`define UFC_LC_TX_WAKE      14
`define UFC_LC_PARITY_EN    3
`define UFC_LC_STOP_LEN     2
`define UFC_LC_MODE_HI      1
`define UFC_LC_MODE_LO      0
`define UFC_LC_RESET        16'h4000

`define UFC_DI_TX_DMA       15
`define UFC_DI_RX_DMA       14
`define UFC_DI_TX_EMPTY     13
`define UFC_DI_RX_FULL      12
`define UFC_DI_RX_ERR       11
`define UFC_DI_CTS_HI       10
`define UFC_DI_CTS_LO       9
`define UFC_DI_SC_HI        5
`define UFC_DI_RESET        16'h0000

`define UFC_SC_OVERRUN      5
`define UFC_SC_CTS          4
`define UFC_SC_BREAK_ACT    3
`define UFC_SC_TX_READY     2
`define UFC_SC_ALL_SENT     1
`define UFC_SC_BREAK_DET    0

`define UFC_EV_TX_EMPTY     0
`define UFC_EV_RX_FULL      1
`define UFC_EV_RX_TIMEOUT   2
`define UFC_EV_RX_ERROR     3
`define UFC_EV_STATUS_CHG   4
`define UFC_EV_COUNT        5

`define UFC_RX_TRIG_DEFAULT 5'h01
`define UFC_RX_DEPTH        16

`endif

// ==== pkg/ufc_pkg.sv ====
// types shared by the serial frame/irq control block
package ufc_pkg;
    typedef enum logic [1:0] {
        UFC_MODE_8BIT,
        UFC_MODE_7BIT,
        UFC_MODE_MC_8BIT,
        UFC_MODE_MC_7BIT
    } ufc_mode_e;

    typedef enum logic [1:0] {
        UFC_CTS_NONE,
        UFC_CTS_RISE,
        UFC_CTS_FALL,
        UFC_CTS_BOTH
    } ufc_cts_e;
endpackage : ufc_pkg

// ==== hdl/ufc_sync.sv ====
// two-stage synchroniser for pin levels
`timescale 1ns/1ns
`default_nettype none
module ufc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule : ufc_sync
`default_nettype wire

// ==== hdl/ufc_edge.sv ====
// per-bit rising and falling edge detector
`timescale 1ns/1ns
`default_nettype none
module ufc_edge #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] prev_ff;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= level_in;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign rise[i] = level_in[i] & ~prev_ff[i];
            assign fall[i] = ~level_in[i] & prev_ff[i];
        end
    endgenerate
endmodule : ufc_edge
`default_nettype wire

// ==== hdl/ufc_ctrl.sv ====
// serial port frame format, dma request and interrupt control
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "ufc_params.svh"

// Contract
// - stop_len 0 gives one stop bit, 1 gives two; resets to 0
// - frame mode 00 8-bit, 01 7-bit, 10/11 multi-controller 8/7-bit
// - transmit dma enable bit 15 gates transmit dma requests
// - receive dma enable bit 14 gates receive dma requests
// - transmit-empty enable bit 13 raises interrupt while tx fifo has space
// - receive enable bit 12 interrupts on receive-full or receive-timeout
// - receive-error enable bit 11 interrupts on receive error events; overrun is a status-change source
// - cts select: 00 none, 01 rise, 10 fall, 11 both edges
// - six-bit enable field picks sources; any selected source firing sets flag
// - sources: overrun, cts event, break, tx ready, all sent, break det
// - interrupt output high while status-change flag is set
// - all enables and the status-change field reset to zero
// - multi-controller frames carry wake-up bit from transmit wake setting
// - receive-full set once rx fifo holds trigger level of data
module ufc_ctrl #(
    parameter int           RX_CNT_W = 5,
    parameter logic [4:0]   RX_TRIG  = `UFC_RX_TRIG_DEFAULT
) (
    input  wire logic                     core_clk,
    input  wire logic                     reset,
    input  wire logic [`UFC_ADDR_W-1:0]   reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [31:0]              reg_rdata,
    input  wire logic                     cts_pin,
    input  wire logic                     tx_fifo_space,
    input  wire logic [RX_CNT_W-1:0]      rx_fifo_count,
    input  wire logic                     rx_timeout_evt,
    input  wire logic                     rx_error_evt,
    input  wire logic                     overrun_evt,
    input  wire logic                     break_active_status,
    input  wire logic                     tx_ready_status,
    input  wire logic                     tx_all_sent_status,
    input  wire logic                     break_detect_status,
    output logic                          tx_dma_req,
    output logic                          rx_dma_req,
    output logic                          two_stop_bits,
    output logic                          frame_7bit,
    output logic                          multi_ctrl_mode,
    output logic                          wakeup_frame_bit,
    output logic                          irq
);
    import ufc_pkg::*;

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [15:0]            line_control_ff;
    logic [15:0]            dma_interrupt_control_ff;
    logic                   rx_timeout_status_ff;
    logic                   rx_error_status_ff;
    logic                   status_change_flag_ff;
    logic                   overrun_status_ff;
    logic [`UFC_EV_COUNT-1:0] irq_sticky_ff;
    logic [`UFC_EV_COUNT-1:0] irq_enable_ff;
    logic [31:0]            reg_rdata_ff;

    ufc_mode_e              frame_mode;
    ufc_cts_e               cts_edge_select;
    logic [5:0]             status_change_enables;
    logic                   cts_sync;
    logic [4:0]             src_level;
    logic [4:0]             src_rise;
    logic [4:0]             src_fall;
    logic                   cts_evt;
    logic [5:0]             sc_source;
    logic                   rx_full_status;
    logic                   tx_empty_cond;
    logic                   rx_cond;
    logic                   err_cond;
    logic [`UFC_EV_COUNT-1:0] ev_now;
    logic [`UFC_EV_COUNT-1:0] irq_clear;
    logic                   wr_line;
    logic                   wr_dma_irq;
    logic                   wr_status;
    logic                   wr_sc_status;
    logic                   wr_irq_en;
    logic                   wr_irq_clr;
    logic [5:0]             sc_status_word;
    logic [15:0]            status_word;

    assign frame_mode = ufc_mode_e'(
        line_control_ff[`UFC_LC_MODE_HI:`UFC_LC_MODE_LO]);
    assign cts_edge_select = ufc_cts_e'(
        dma_interrupt_control_ff[`UFC_DI_CTS_HI:`UFC_DI_CTS_LO]);
    assign status_change_enables =
        dma_interrupt_control_ff[`UFC_DI_SC_HI:0];

    assign wr_line      = reg_wr && (reg_addr == `UFC_OFS_LINE_CTRL);
    assign wr_dma_irq   = reg_wr && (reg_addr == `UFC_OFS_DMA_IRQ);
    assign wr_status    = reg_wr && (reg_addr == `UFC_OFS_IRQ_STATUS);
    assign wr_sc_status = reg_wr && (reg_addr == `UFC_OFS_SC_STATUS);
    assign wr_irq_en    = reg_wr && (reg_addr == `UFC_OFS_IRQ_ENABLE);
    assign wr_irq_clr   = reg_wr && (reg_addr == `UFC_OFS_IRQ_CLEAR);

    // ----------------------------------------------------------------
    // pin synchronisation and edge detection
    // ----------------------------------------------------------------
    ufc_sync #(
        .WIDTH    (1)
    ) u_cts_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in (cts_pin),
        .sync_out (cts_sync)
    );

    assign src_level = {cts_sync, break_active_status, tx_ready_status,
                        tx_all_sent_status, break_detect_status};

    ufc_edge #(
        .WIDTH    (5)
    ) u_edge (
        .core_clk (core_clk),
        .reset    (reset),
        .level_in (src_level),
        .rise     (src_rise),
        .fall     (src_fall)
    );

    // ----------------------------------------------------------------
    // status-change sources
    // ----------------------------------------------------------------
    always_comb begin
        case (cts_edge_select)
            UFC_CTS_NONE: cts_evt = 1'b0;
            UFC_CTS_RISE: cts_evt = src_rise[4];
            UFC_CTS_FALL: cts_evt = src_fall[4];
            UFC_CTS_BOTH: cts_evt = src_rise[4] | src_fall[4];
            default:      cts_evt = 1'b0;
        endcase
    end

    // overrun is a level source, cts fires on its selected edge, the others fire on becoming 1
    assign sc_source = {overrun_status_ff, cts_evt, src_rise[3],
                        src_rise[2], src_rise[1], src_rise[0]};

    // ----------------------------------------------------------------
    // line control
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            line_control_ff <= `UFC_LC_RESET;
        end else if (wr_line) begin
            line_control_ff <= reg_wdata[15:0] & 16'hc01f;
        end
    end

    // ----------------------------------------------------------------
    // dma / interrupt control
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dma_interrupt_control_ff <= `UFC_DI_RESET;
        end else if (wr_dma_irq) begin
            dma_interrupt_control_ff <= reg_wdata[15:0] & 16'hfe3f;
        end
    end

    // ----------------------------------------------------------------
    // sticky status bits, write 0 to clear, set wins
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rx_timeout_status_ff  <= 1'b0;
            rx_error_status_ff    <= 1'b0;
            status_change_flag_ff <= 1'b0;
        end else begin
            if (rx_timeout_evt) begin
                rx_timeout_status_ff <= 1'b1;
            end else if (wr_status && !reg_wdata[9]) begin
                rx_timeout_status_ff <= 1'b0;
            end
            if (rx_error_evt) begin
                rx_error_status_ff <= 1'b1;
            end else if (wr_status && !reg_wdata[10]) begin
                rx_error_status_ff <= 1'b0;
            end
            if (|(sc_source & status_change_enables)) begin
                status_change_flag_ff <= 1'b1;
            end else if (wr_status && !reg_wdata[6]) begin
                status_change_flag_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            overrun_status_ff <= 1'b0;
        end else if (overrun_evt) begin
            overrun_status_ff <= 1'b1;
        end else if (wr_sc_status && !reg_wdata[`UFC_SC_OVERRUN]) begin
            overrun_status_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // interrupt conditions
    // ----------------------------------------------------------------
    assign rx_full_status = (rx_fifo_count >= RX_CNT_W'(RX_TRIG));
    assign tx_empty_cond  = dma_interrupt_control_ff[`UFC_DI_TX_EMPTY]
                            & tx_fifo_space;
    assign rx_cond        = dma_interrupt_control_ff[`UFC_DI_RX_FULL]
                            & (rx_full_status | rx_timeout_status_ff);
    assign err_cond       = dma_interrupt_control_ff[`UFC_DI_RX_ERR]
                            & rx_error_status_ff;

    assign ev_now = {status_change_flag_ff, err_cond,
                     rx_cond & rx_timeout_status_ff,
                     rx_cond & rx_full_status, tx_empty_cond};
    assign irq_clear = wr_irq_clr ? reg_wdata[`UFC_EV_COUNT-1:0] : '0;

    genvar e;
    generate
        for (e = 0; e < `UFC_EV_COUNT; e++) begin : g_sticky
            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    irq_sticky_ff[e] <= 1'b0;
                end else if (ev_now[e]) begin
                    irq_sticky_ff[e] <= 1'b1;
                end else if (irq_clear[e]) begin
                    irq_sticky_ff[e] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irq_enable_ff <= '0;
        end else if (wr_irq_en) begin
            irq_enable_ff <= reg_wdata[`UFC_EV_COUNT-1:0];
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irq              <= 1'b0;
            tx_dma_req       <= 1'b0;
            rx_dma_req       <= 1'b0;
            two_stop_bits    <= 1'b0;
            frame_7bit       <= 1'b0;
            multi_ctrl_mode  <= 1'b0;
            wakeup_frame_bit <= 1'b0;
        end else begin
            irq <= |(irq_sticky_ff & irq_enable_ff)
                   | status_change_flag_ff
                   | tx_empty_cond | rx_cond | err_cond;
            tx_dma_req <= dma_interrupt_control_ff[`UFC_DI_TX_DMA]
                          & tx_fifo_space;
            rx_dma_req <= dma_interrupt_control_ff[`UFC_DI_RX_DMA]
                          & rx_full_status;
            two_stop_bits <= line_control_ff[`UFC_LC_STOP_LEN];
            frame_7bit <= (frame_mode == UFC_MODE_7BIT)
                          || (frame_mode == UFC_MODE_MC_7BIT);
            multi_ctrl_mode <= line_control_ff[`UFC_LC_MODE_HI];
            wakeup_frame_bit <= line_control_ff[`UFC_LC_MODE_HI]
                                & line_control_ff[`UFC_LC_TX_WAKE];
        end
    end

    // ----------------------------------------------------------------
    // register read
    // ----------------------------------------------------------------
    assign sc_status_word = {overrun_status_ff, cts_sync,
                             break_active_status, tx_ready_status,
                             tx_all_sent_status, 1'b0};
    assign status_word = {5'h00, rx_error_status_ff, rx_timeout_status_ff,
                          tx_fifo_space, rx_full_status,
                          status_change_flag_ff, 6'h00};

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata_ff <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `UFC_OFS_LINE_CTRL:  reg_rdata_ff <= {16'h0000, line_control_ff};
                `UFC_OFS_DMA_IRQ:
                    reg_rdata_ff <= {16'h0000, dma_interrupt_control_ff};
                `UFC_OFS_IRQ_STATUS: reg_rdata_ff <= {16'h0000, status_word};
                `UFC_OFS_SC_STATUS:  reg_rdata_ff <= {26'h0, sc_status_word};
                `UFC_OFS_IRQ_ENABLE: reg_rdata_ff <= {27'h0, irq_enable_ff};
                `UFC_OFS_IRQ_CLEAR:  reg_rdata_ff <= {27'h0, irq_sticky_ff};
                default:             reg_rdata_ff <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_ff <= 32'h0000_0000;
        end
    end

    assign reg_rdata = reg_rdata_ff;
endmodule : ufc_ctrl
`default_nettype wire

// ==== verif/ufc_ctrl_assertions.sv ====
// port-level checks for the serial frame/irq control
`timescale 1ns/1ns
`default_nettype none
`include "ufc_params.svh"
module ufc_ctrl_checker #(
    parameter int         RX_CNT_W = 5,
    parameter logic [4:0] RX_TRIG  = 5'h01
) (
    input wire logic                   core_clk,
    input wire logic                   reset,
    input wire logic [`UFC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0]            reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [31:0]            reg_rdata,
    input wire logic                   cts_pin,
    input wire logic                   tx_fifo_space,
    input wire logic [RX_CNT_W-1:0]    rx_fifo_count,
    input wire logic                   rx_timeout_evt,
    input wire logic                   rx_error_evt,
    input wire logic                   overrun_evt,
    input wire logic                   tx_dma_req,
    input wire logic                   rx_dma_req,
    input wire logic                   two_stop_bits,
    input wire logic                   frame_7bit,
    input wire logic                   multi_ctrl_mode,
    input wire logic                   wakeup_frame_bit,
    input wire logic                   irq
);
    logic [15:0] en_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // mirror of the dma/interrupt enables
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            en_ff <= 16'h0000;
        end else if (reg_wr && reg_addr == `UFC_OFS_DMA_IRQ) begin
            en_ff <= reg_wdata[15:0];
        end
    end

    sequence s_lc_wr;
        reg_wr && reg_addr == `UFC_OFS_LINE_CTRL;
    endsequence
    sequence s_overrun;
        en_ff[`UFC_SC_OVERRUN] && overrun_evt;
    endsequence
    sequence s_cts_rise;
        en_ff[`UFC_SC_CTS] && en_ff[`UFC_DI_CTS_LO] && $rose(cts_pin);
    endsequence

    AST_STOP_LEN: assert property (s_lc_wr |-> ##2
        two_stop_bits == $past(reg_wdata[`UFC_LC_STOP_LEN], 2))
        else $error("stop length output mismatch");
    AST_MODE: assert property (s_lc_wr |-> ##2
        frame_7bit == $past(reg_wdata[0], 2) &&
        multi_ctrl_mode == $past(reg_wdata[1], 2))
        else $error("frame mode outputs mismatch");
    AST_WAKE: assert property (s_lc_wr |-> ##2
        wakeup_frame_bit == ($past(reg_wdata[1], 2) &&
                             $past(reg_wdata[`UFC_LC_TX_WAKE], 2)))
        else $error("wake-up bit output mismatch");
    AST_TX_DMA: assert property (
        tx_dma_req == ($past(en_ff[`UFC_DI_TX_DMA]) && $past(tx_fifo_space)))
        else $error("transmit dma request mismatch");
    AST_RX_DMA: assert property (
        rx_dma_req == ($past(en_ff[`UFC_DI_RX_DMA]) &&
                       $past(rx_fifo_count) >= RX_TRIG))
        else $error("receive dma request mismatch");
    AST_TX_EMPTY_IRQ: assert property (
        en_ff[`UFC_DI_TX_EMPTY] && tx_fifo_space |-> ##[1:2] irq)
        else $error("transmit empty interrupt missing");
    AST_TIMEOUT_IRQ: assert property (
        en_ff[`UFC_DI_RX_FULL] && rx_timeout_evt |-> ##[1:3] irq)
        else $error("receive timeout interrupt missing");
    AST_ERR_IRQ: assert property (
        en_ff[`UFC_DI_RX_ERR] && rx_error_evt |-> ##[1:3] irq)
        else $error("receive error interrupt missing");
    AST_OVERRUN_IRQ: assert property (s_overrun |-> ##[2:4] irq)
        else $error("overrun status change interrupt missing");
    AST_CTS_IRQ: assert property (s_cts_rise |-> ##[3:7] irq)
        else $error("cts edge interrupt missing");
    AST_RESET_QUIET: assert property ($fell(reset) |->
        !irq && !tx_dma_req && !rx_dma_req)
        else $error("outputs active after reset");
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read answer cycle");
endmodule : ufc_ctrl_checker
`default_nettype wire

// ==== verif/ufc_remote_model.sv ====
// remote serial device: drives the clear-to-send pin
`timescale 1ns/1ns
`default_nettype none
module ufc_remote_model (
    input  wire logic core_clk,
    output var  logic cts_pin
);
    initial cts_pin = 1'b0;

    // pin changes just after a clock edge
    task automatic set_cts(input logic lvl);
        @(posedge core_clk);
        cts_pin <= lvl;
    endtask : set_cts
endmodule : ufc_remote_model
`default_nettype wire

// ==== verif/uart_frame_and_host_irq_dma_ctrl_tb_top.sv ====
// self-checking bench for the serial frame/irq control
`timescale 1ns/1ns
`default_nettype none
`include "ufc_params.svh"
module uart_frame_and_host_irq_dma_ctrl_tb_top;
    localparam logic [4:0] TRIG = 5'h03;
    logic        core_clk;
    logic        reset;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    wire logic   cts_pin;
    logic        tx_fifo_space;
    logic [4:0]  rx_fifo_count;
    logic [2:0]  evt;
    logic [3:0]  src;
    logic        tx_dma_req;
    logic        rx_dma_req;
    wire logic [3:0] fmt;
    logic        irq;
    logic [15:0] d;
    int          n_fail;
    int          comparisons;

    ufc_ctrl #(.RX_CNT_W(5), .RX_TRIG(TRIG)) dut_u (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cts_pin(cts_pin),
        .tx_fifo_space(tx_fifo_space), .rx_fifo_count(rx_fifo_count),
        .rx_timeout_evt(evt[0]), .rx_error_evt(evt[1]),
        .overrun_evt(evt[2]), .break_detect_status(src[0]),
        .tx_all_sent_status(src[1]), .tx_ready_status(src[2]),
        .break_active_status(src[3]), .tx_dma_req(tx_dma_req),
        .rx_dma_req(rx_dma_req), .frame_7bit(fmt[0]),
        .multi_ctrl_mode(fmt[1]), .two_stop_bits(fmt[2]),
        .wakeup_frame_bit(fmt[3]), .irq(irq));
    ufc_remote_model rem_u (.core_clk(core_clk), .cts_pin(cts_pin));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= {16'h0000, v};
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rdm(input logic [15:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata & m, e);
    endtask : rdm

    task automatic pulse(input int k);
        @(posedge core_clk);
        evt[k] <= 1'b1;
        @(posedge core_clk);
        evt[k] <= 1'b0;
    endtask : pulse

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        $display("watchdog expired");
        report_and_stop();
    end

    initial begin
        n_fail = 0;
        comparisons = 0;
        reset = 1'b1;
        reg_addr = 16'h0000;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        tx_fifo_space = 1'b0;
        rx_fifo_count = 5'h00;
        evt = 3'h0;
        src = 4'h0;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        settle(1);
        chk({irq, tx_dma_req, rx_dma_req}, 32'h0);
        rdm(`UFC_OFS_LINE_CTRL, 32'hffffffff, 32'h4000);
        rdm(`UFC_OFS_DMA_IRQ, 32'hffffffff, 32'h0);
        rdm(16'hf310, 32'hffffffff, 32'h0);
        $display("test reset values done");
        for (int v = 0; v < 16; v++) begin
            d = {1'b0, v[3], 11'h000, v[2:0]};
            wr(`UFC_OFS_LINE_CTRL, d);
            settle(1);
            chk({28'h0, fmt}, {v[3] & v[1], v[2:0]});
            rdm(`UFC_OFS_LINE_CTRL, 32'hffffffff, {16'h0, d});
        end
        wr(`UFC_OFS_LINE_CTRL, 16'hfff7);
        rdm(`UFC_OFS_LINE_CTRL, 32'hffffffff, 32'hc017);
        wr(`UFC_OFS_DMA_IRQ, 16'h89ff);
        rdm(`UFC_OFS_DMA_IRQ, 32'hffffffff, 32'h883f);
        $display("test format and fields done");
        @(posedge core_clk) tx_fifo_space <= 1'b1;
        wr(`UFC_OFS_DMA_IRQ, 16'h8000);
        settle(2);
        chk({tx_dma_req, rx_dma_req}, 32'h2);
        @(posedge core_clk) tx_fifo_space <= 1'b0;
        settle(2);
        chk(tx_dma_req, 32'h0);
        wr(`UFC_OFS_DMA_IRQ, 16'h4000);
        @(posedge core_clk) rx_fifo_count <= TRIG - 5'h01;
        settle(2);
        chk(rx_dma_req, 32'h0);
        @(posedge core_clk) rx_fifo_count <= TRIG;
        settle(2);
        chk({tx_dma_req, rx_dma_req}, 32'h1);
        wr(`UFC_OFS_DMA_IRQ, 16'h1000);
        settle(2);
        chk({irq, rx_dma_req}, 32'h2);
        @(posedge core_clk) rx_fifo_count <= 5'h00;
        @(posedge core_clk) tx_fifo_space <= 1'b1;
        wr(`UFC_OFS_DMA_IRQ, 16'h2000);
        settle(2);
        chk(irq, 32'h1);
        wr(`UFC_OFS_DMA_IRQ, 16'h0000);
        @(posedge core_clk) tx_fifo_space <= 1'b0;
        settle(2);
        chk(irq, 32'h0);
        $display("test dma and fifo interrupts done");
        for (int k = 0; k < 2; k++) begin
            d = k == 0 ? 16'hfdff : 16'hfbff;
            pulse(k);
            settle(3);
            chk(irq, 32'h0);
            wr(`UFC_OFS_DMA_IRQ, k == 0 ? 16'h1000 : 16'h0800);
            settle(2);
            chk(irq, 32'h1);
            wr(`UFC_OFS_IRQ_STATUS, d);
            settle(2);
            chk(irq, 32'h0);
            pulse(k);
            settle(3);
            chk(irq, 32'h1);
            wr(`UFC_OFS_IRQ_STATUS, d);
            wr(`UFC_OFS_DMA_IRQ, 16'h0000);
        end
        wr(`UFC_OFS_DMA_IRQ, 16'h0020);
        pulse(2);
        settle(4);
        chk(irq, 32'h1);
        rdm(`UFC_OFS_SC_STATUS, 32'h20, 32'h20);
        wr(`UFC_OFS_SC_STATUS, 16'hffdf);
        wr(`UFC_OFS_IRQ_STATUS, 16'hffbf);
        settle(2);
        chk(irq, 32'h0);
        $display("test error and overrun done");
        for (int s = 0; s < 4; s++) begin
            wr(`UFC_OFS_DMA_IRQ, 16'h0010 | 16'(s << 9));
            rem_u.set_cts(1'b1);
            settle(8);
            rdm(`UFC_OFS_IRQ_STATUS, 32'h40, {25'h0, s[0], 6'h0});
            chk(irq, s[0]);
            wr(`UFC_OFS_IRQ_STATUS, 16'hffbf);
            rem_u.set_cts(1'b0);
            settle(8);
            rdm(`UFC_OFS_IRQ_STATUS, 32'h40, {25'h0, s[1], 6'h0});
            wr(`UFC_OFS_IRQ_STATUS, 16'hffbf);
        end
        $display("test cts edges done");
        for (int i = 0; i < 4; i++) begin
            wr(`UFC_OFS_DMA_IRQ, 16'h0000);
            @(posedge core_clk) src[i] <= 1'b1;
            settle(4);
            rdm(`UFC_OFS_IRQ_STATUS, 32'h40, 32'h0);
            @(posedge core_clk) src[i] <= 1'b0;
            wr(`UFC_OFS_DMA_IRQ, 16'(1 << i));
            @(posedge core_clk) src[i] <= 1'b1;
            settle(4);
            rdm(`UFC_OFS_IRQ_STATUS, 32'h40, 32'h40);
            chk(irq, 32'h1);
            @(posedge core_clk) src[i] <= 1'b0;
            wr(`UFC_OFS_IRQ_STATUS, 16'hffbf);
        end
        wr(`UFC_OFS_IRQ_ENABLE, 16'h001f);
        settle(1);
        chk(irq, 32'h1);
        rdm(`UFC_OFS_IRQ_CLEAR, 32'hffffffff, 32'h1f);
        wr(`UFC_OFS_IRQ_CLEAR, 16'h001f);
        settle(2);
        chk(irq, 32'h0);
        $display("test status change sources done");
        report_and_stop();
    end
endmodule : uart_frame_and_host_irq_dma_ctrl_tb_top

bind ufc_ctrl ufc_ctrl_checker #(.RX_CNT_W(RX_CNT_W), .RX_TRIG(RX_TRIG)) chk_u (
    .core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cts_pin, .tx_fifo_space, .rx_fifo_count, .rx_timeout_evt, .rx_error_evt,
    .overrun_evt, .tx_dma_req, .rx_dma_req, .two_stop_bits, .frame_7bit,
    .multi_ctrl_mode, .wakeup_frame_bit, .irq);
`default_nettype wire
